/* File: src/pcd_pkg.sv */
package pcd_pkg;

  // =====================================================================
  // clock and timing
  // =====================================================================
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned T_OFF_NS      = 1500000;
  localparam int unsigned T_SETP_NS     = 10000;
  localparam int unsigned T_PULSE_NS    = 300;
  localparam int unsigned T_GAP_NS      = 300;
  localparam int unsigned T_MODE_NS     = 400000;
  localparam int unsigned T_PERIOD_NS   = 1000;
  // least times round up, longest times round down
  localparam int unsigned OFF_CYC   = (T_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETP_CYC  = (T_SETP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_CYC   = (T_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MODE_CYC  = (T_MODE_NS * CLK_MHZ) / 1000;
  localparam int unsigned PERIOD_CYC = (T_PERIOD_NS * CLK_MHZ + 999) / 1000;

  // =====================================================================
  // current setting
  // =====================================================================
  localparam int unsigned LVL_W    = 5;
  localparam logic [4:0]  LVL_FULL = 5'h1f;
  localparam logic [4:0]  LVL_ZERO = 5'h00;
  localparam int unsigned NUM_CH   = 4;
  localparam int unsigned TMR_W    = 20;

  typedef enum logic [1:0] {
    PCD_SHDN  = 2'b00,
    PCD_WAIT  = 2'b01,
    PCD_DIM   = 2'b11
  } pcd_state_t;

  typedef enum logic [1:0] {
    PCH_IDLE  = 2'b00,
    PCH_SETUP = 2'b01,
    PCH_HIGH  = 2'b11,
    PCH_LOW   = 2'b10
  } pcd_host_state_t;

endpackage

/* File: src/pcd_link_if.sv */
`timescale 1ns/1ps
interface pcd_link_if;
  logic dim_enable_line;
  modport device (input dim_enable_line);
  modport host   (output dim_enable_line);
endinterface

/* File: src/pcd_device.sv */
`timescale 1ns/1ps
module pcd_device
  import pcd_pkg::*;
#(
  parameter int unsigned OFF_CYCLES  = OFF_CYC,
  parameter int unsigned MODE_CYCLES = MODE_CYC
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  input  wire logic              i_ce,
  pcd_link_if.device             link,
  input  wire logic              i_supply_undervoltage_lock,
  input  wire logic              i_over_temp,
  input  wire logic              i_reg_short,
  input  wire logic [NUM_CH-1:0] i_sink_tied_pump_output,
  output logic [LVL_W-1:0]       o_level,
  output logic [NUM_CH-1:0]      o_sink_en,
  output logic                   o_enabled,
  output logic                   o_pump_1p5x
);

  // =====================================================================
  // pin synchroniser
  // =====================================================================
  logic       line_s1_r;
  logic       line_s2_r;
  logic       line_d_r;
  // the third flop only feeds the edge detector
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      line_s1_r <= 1'b0;
      line_s2_r <= 1'b0;
      line_d_r  <= 1'b0;
    end else if (i_ce) begin
      line_s1_r <= link.dim_enable_line;
      line_s2_r <= line_s1_r;
      line_d_r  <= line_s2_r;
    end
  end

  // =====================================================================
  // status pin synchroniser
  // =====================================================================
  // status flags come from the analog side, so they get two flops as well
  localparam int unsigned PIN_W = NUM_CH + 3;
  wire  [PIN_W-1:0] pin_w = {i_reg_short, i_over_temp, i_supply_undervoltage_lock,
                             i_sink_tied_pump_output};
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else if (i_ce) begin
      pin_s1_r <= pin_w;
      pin_s2_r <= pin_s1_r;
    end
  end

  wire              reg_short_w = pin_s2_r[NUM_CH+2];
  wire              over_temp_w = pin_s2_r[NUM_CH+1];
  wire              undervolt_w = pin_s2_r[NUM_CH];
  wire [NUM_CH-1:0] tied_w      = pin_s2_r[NUM_CH-1:0];

  wire fall_w = line_d_r & ~line_s2_r;
  wire rise_w = ~line_d_r & line_s2_r;

  // =====================================================================
  // control state and level
  // =====================================================================
  pcd_state_t       st_r;
  pcd_state_t       st_nxt;
  logic [LVL_W-1:0] lvl_r;
  logic [LVL_W-1:0] lvl_nxt;
  logic [TMR_W-1:0] low_r;
  logic [TMR_W-1:0] mode_r;
  logic             pump_r;

  // timer stops at its limit so it never wraps back under the threshold
  wire off_hit_w  = (low_r >= TMR_W'(OFF_CYCLES));
  wire thermal_w  = over_temp_w;

  always_comb begin
    st_nxt  = st_r;
    lvl_nxt = lvl_r;
    case (st_r)
      PCD_SHDN: begin
        if (rise_w) begin
          st_nxt  = PCD_WAIT;
          lvl_nxt = LVL_ZERO;
        end
      end
      PCD_WAIT: begin
        if (off_hit_w) begin
          st_nxt = PCD_SHDN;
        end else if (fall_w) begin
          st_nxt  = PCD_DIM;
          lvl_nxt = LVL_FULL;
        end
      end
      PCD_DIM: begin
        if (off_hit_w) begin
          st_nxt  = PCD_SHDN;
          lvl_nxt = LVL_ZERO;
        end else if (fall_w) begin
          // 31 then 30..0 puts zero on the 32nd pulse, then wraps
          if (lvl_r == LVL_ZERO) begin
            lvl_nxt = LVL_FULL;
          end else begin
            lvl_nxt = lvl_r - 5'h01;
          end
        end
      end
      default: begin
        st_nxt  = PCD_SHDN;
        lvl_nxt = LVL_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_r  <= PCD_SHDN;
      lvl_r <= LVL_ZERO;
      low_r <= '0;
    end else if (i_ce) begin
      st_r  <= st_nxt;
      lvl_r <= lvl_nxt;
      if (line_s2_r) begin
        low_r <= '0;
      end else if (!off_hit_w) begin
        low_r <= low_r + 20'h00001;
      end
    end
  end

  // =====================================================================
  // pump mode sequence
  // =====================================================================
  // a drop of the weak-pump flag restarts the delay but keeps 1.5x
  wire restart_w = (st_r == PCD_SHDN);
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pump_r <= 1'b0;
      mode_r <= '0;
    end else if (i_ce) begin
      if (restart_w || !reg_short_w) begin
        mode_r <= '0;
        if (restart_w) begin
          pump_r <= 1'b0;
        end
      end else if (mode_r >= TMR_W'(MODE_CYCLES - 1)) begin
        pump_r <= 1'b1;
      end else begin
        mode_r <= mode_r + 20'h00001;
      end
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  // protection gates the sinks and forces o_level to zero; the stored setting survives a fault
  // built from the next state so the registers change together with o_enabled
  logic [LVL_W-1:0]  level_r;
  logic [NUM_CH-1:0] sink_r;
  wire              run_nxt   = (st_nxt != PCD_SHDN) & ~undervolt_w & ~thermal_w;
  wire [NUM_CH-1:0] sink_nxt  = {NUM_CH{run_nxt}} & ~tied_w;
  wire [LVL_W-1:0]  level_nxt = run_nxt ? lvl_nxt : LVL_ZERO;

  // =====================================================================
  // output registers
  // =====================================================================
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      level_r <= LVL_ZERO;
      sink_r  <= '0;
    end else if (i_ce) begin
      level_r <= level_nxt;
      sink_r  <= sink_nxt;
    end
  end

  assign o_sink_en   = sink_r;
  assign o_level     = level_r;
  assign o_enabled   = (st_r != PCD_SHDN);
  assign o_pump_1p5x = pump_r;

endmodule

/* File: src/pcd_host.sv */
`timescale 1ns/1ps
module pcd_host
  import pcd_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = OFF_CYC
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_b,
  input  wire logic             i_ce,
  pcd_link_if.host              link,
  input  wire logic             i_enable,
  input  wire logic             i_pulse_req,
  output logic                  o_ready
);

  // =====================================================================
  // line sequencer
  // =====================================================================
  pcd_host_state_t  st_r;
  logic [TMR_W-1:0] cnt_r;
  logic             line_r;
  logic             on_r;

  wire setp_done_w = (cnt_r >= TMR_W'(SETP_CYC - 1));
  wire low_done_w  = (cnt_r >= TMR_W'(PULSE_CYC - 1));
  // gap is stretched so the pulse period never beats the top rate
  wire gap_done_w  = (cnt_r >= TMR_W'(GAP_CYC - 1)) &&
                     (cnt_r >= TMR_W'(PERIOD_CYC - PULSE_CYC - 1));
  wire off_done_w  = (cnt_r >= TMR_W'(OFF_CYCLES));

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_r   <= PCH_IDLE;
      cnt_r  <= '0;
      line_r <= 1'b0;
      on_r   <= 1'b0;
    end else if (i_ce) begin
      cnt_r <= cnt_r + 20'h00001;
      case (st_r)
        PCH_IDLE: begin
          if (!off_done_w) begin
            line_r <= 1'b0;
          end else if (i_enable) begin
            st_r   <= PCH_SETUP;
            line_r <= 1'b1;
            cnt_r  <= '0;
          end else begin
            cnt_r <= cnt_r;
            on_r  <= 1'b0;
          end
        end
        PCH_SETUP: begin
          if (!i_enable) begin
            st_r   <= PCH_IDLE;
            line_r <= 1'b0;
            cnt_r  <= '0;
          end else if (setp_done_w) begin
            st_r  <= PCH_HIGH;
            on_r  <= 1'b1;
            cnt_r <= '0;
          end
        end
        PCH_HIGH: begin
          if (!i_enable) begin
            st_r   <= PCH_IDLE;
            line_r <= 1'b0;
            cnt_r  <= '0;
          end else if (gap_done_w && i_pulse_req) begin
            st_r   <= PCH_LOW;
            line_r <= 1'b0;
            cnt_r  <= '0;
          end else if (gap_done_w) begin
            cnt_r <= cnt_r;
          end
        end
        PCH_LOW: begin
          // pulse is exactly the minimum width, far under 200 us
          if (low_done_w) begin
            st_r   <= PCH_HIGH;
            line_r <= 1'b1;
            cnt_r  <= '0;
          end
        end
        default: begin
          st_r   <= PCH_IDLE;
          line_r <= 1'b0;
          cnt_r  <= '0;
        end
      endcase
    end
  end

  assign link.dim_enable_line = line_r;
  assign o_ready = (st_r == PCH_HIGH) & gap_done_w & i_enable & on_r;

endmodule

/* File: sim/pcd_properties.sv */
`timescale 1ns/1ps
module pcd_properties
  import pcd_pkg::*;
#(
  parameter int unsigned OFF_CYCLES  = OFF_CYC,
  parameter int unsigned MODE_CYCLES = MODE_CYC
) (
  input wire logic              i_mclk,
  input wire logic              i_rst_b,
  input wire logic              dim_enable_line,
  input wire logic              i_supply_undervoltage_lock,
  input wire logic              i_over_temp,
  input wire logic              i_reg_short,
  input wire logic [NUM_CH-1:0] i_sink_tied_pump_output,
  input wire logic [LVL_W-1:0]  o_level,
  input wire logic [NUM_CH-1:0] o_sink_en,
  input wire logic              o_enabled,
  input wire logic              o_pump_1p5x
);
  // ==========
  // low time and weak-pump counters
  logic [19:0] lo_cnt_r;
  logic [19:0] rs_cnt_r;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || dim_enable_line) lo_cnt_r <= 20'h0;
    else if (lo_cnt_r != 20'hfffff) lo_cnt_r <= lo_cnt_r + 20'h1;
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !i_reg_short || !o_enabled) rs_cnt_r <= 20'h0;
    else rs_cnt_r <= rs_cnt_r + 20'h1;
  end
  // ==========
  // properties; level follows a line edge after 3 cycles of sync and decode, checked 4 cycles on
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence fall_s;
    $fell(dim_enable_line) && o_enabled;
  endsequence
  enable_zero_a: assert property ($rose(dim_enable_line) && !o_enabled |-> ##4 o_enabled && o_level == 5'h00)
    else $error("enable did not start at zero");
  full_load_a: assert property (fall_s ##0 o_level == 5'h00 |-> ##4 o_level == LVL_FULL)
    else $error("zero level not loaded to full");
  step_down_a: assert property (fall_s ##0 o_level != 5'h00 |-> ##4 o_level == $past(o_level, 4) - 5'h01)
    else $error("level did not step down");
  shdn_hiz_a: assert property (!o_enabled |-> o_sink_en == 4'h0 && o_level == 5'h00)
    else $error("sinks active in shutdown");
  shdn_late_a: assert property (lo_cnt_r > OFF_CYCLES + 8 |-> !o_enabled)
    else $error("no shutdown after long low");
  shdn_early_a: assert property ($fell(o_enabled) |-> lo_cnt_r >= OFF_CYCLES)
    else $error("shutdown before low time");
  pump_start_a: assert property ($rose(o_enabled) |-> !o_pump_1p5x)
    else $error("pump not unity at enable");
  pump_early_a: assert property ($rose(o_pump_1p5x) |-> rs_cnt_r >= MODE_CYCLES - 2)
    else $error("pump switched early");
  pump_late_a: assert property (rs_cnt_r > MODE_CYCLES + 3 |-> o_pump_1p5x)
    else $error("pump switch missing");
  // fault pins pass two sync flops and the output register
  sink_gate_a: assert property (i_supply_undervoltage_lock || i_over_temp |-> ##3 o_sink_en == 4'h0)
    else $error("sinks on under fault");
  tied_off_a: assert property ($stable(i_sink_tied_pump_output) [*3] |-> (o_sink_en & i_sink_tied_pump_output) == 4'h0)
    else $error("tied sink enabled");
endmodule

/* File: sim/pulse_count_led_dimming_tb.sv */
`timescale 1ns/1ps
module pulse_count_led_dimming_tb;
  import pcd_pkg::*;
  // ==========
  // short counts keep the run small
  localparam int unsigned OFFC  = 200;
  localparam int unsigned MODEC = 50;
  logic       i_mclk    = 1'b0;
  logic       i_rst_b   = 1'b0;
  logic       enable    = 1'b0;
  logic       pulse_req = 1'b0;
  logic       uv        = 1'b0;
  logic       ot        = 1'b0;
  logic       reg_short = 1'b0;
  logic [3:0] tied      = 4'h0;
  logic       ready;
  logic       enabled;
  logic       pump;
  logic [4:0] level;
  logic [3:0] sink_en;
  int         err_total       = 0;
  int         samples_checked = 0;
  pcd_link_if link ();
  pcd_host #(.OFF_CYCLES(OFFC)) i_pcd_host (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(1'b1),
    .link(link), .i_enable(enable), .i_pulse_req(pulse_req), .o_ready(ready));
  pcd_device #(.OFF_CYCLES(OFFC), .MODE_CYCLES(MODEC)) i_pcd_device (.i_mclk(i_mclk),
    .i_rst_b(i_rst_b), .i_ce(1'b1), .link(link), .i_supply_undervoltage_lock(uv),
    .i_over_temp(ot), .i_reg_short(reg_short), .i_sink_tied_pump_output(tied),
    .o_level(level), .o_sink_en(sink_en), .o_enabled(enabled), .o_pump_1p5x(pump));
  pcd_properties #(.OFF_CYCLES(OFFC), .MODE_CYCLES(MODEC)) i_pcd_properties (.i_mclk(i_mclk),
    .i_rst_b(i_rst_b), .dim_enable_line(link.dim_enable_line),
    .i_supply_undervoltage_lock(uv), .i_over_temp(ot), .i_reg_short(reg_short),
    .i_sink_tied_pump_output(tied), .o_level(level), .o_sink_en(sink_en),
    .o_enabled(enabled), .o_pump_1p5x(pump));
  initial forever #2 i_mclk = ~i_mclk;
  // ==========
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 5000) begin
      @(negedge i_mclk);
      k++;
    end
    chk({7'h0, ready}, 8'h01);
  endtask
  // one pulse, then wait until the host may take the next
  task automatic pulse;
    wait_ready;
    pulse_req = 1'b1;
    @(negedge i_mclk);
    pulse_req = 1'b0;
    @(negedge i_mclk);
    wait_ready;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    cyc(4);
    i_rst_b = 1'b1;
    enable = 1'b1;
    wait_ready;
    chk(level, 8'h00);
    chk(enabled, 8'h01);
    $display("test enable done");
    for (int k = 1; k <= 33; k++) begin
      pulse;
      chk(level, (k == 33) ? 8'h1f : 8'(32 - k));
    end
    $display("test dimming done");
    // fault pins pass two sync flops and the output register
    uv = 1'b1;
    cyc(4);
    chk(sink_en, 8'h00);
    uv = 1'b0;
    ot = 1'b1;
    cyc(4);
    chk(sink_en, 8'h00);
    ot = 1'b0;
    tied = 4'h5;
    cyc(4);
    chk(sink_en, 8'h0a);
    tied = 4'h0;
    cyc(4);
    chk(level, 8'h1f);
    $display("test faults done");
    reg_short = 1'b1;
    cyc(MODEC - 6);
    chk(pump, 8'h00);
    cyc(12);
    chk(pump, 8'h01);
    reg_short = 1'b0;
    $display("test pump done");
    enable = 1'b0;
    cyc(OFFC - 10);
    chk(enabled, 8'h01);
    cyc(30);
    chk(enabled, 8'h00);
    chk(sink_en, 8'h00);
    enable = 1'b1;
    wait_ready;
    chk(pump, 8'h00);
    chk(level, 8'h00);
    pulse;
    chk(level, 8'h1f);
    $display("test shutdown done");
    report_and_stop;
  end
  // a hang counts as a mismatch
  initial begin
    cyc(30000);
    err_total++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
    report_and_stop;
  end
endmodule
